// *** design/srx_pkg.sv ***
// shared constants and types for the special-register / subtract / swap / halt executor
package srx_pkg;
    localparam int DATA_W      = 8;
    localparam int SPEC_N      = 22;   // special-page registers, index 0..21
    localparam int SPEC_IDX_W  = 5;
    localparam int FILE_N      = 128;  // file registers, address 0..127
    localparam int FILE_ADDR_W = 7;
    localparam int WDT_W       = 8;
    localparam int PRE_W       = 8;
    localparam int NIB         = 4;

    // register port map
    localparam logic [7:0] ADDR_ACC     = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h01;
    localparam logic [7:0] ADDR_TMRMODE = 8'h02;
    localparam logic [7:0] ADDR_WDT     = 8'h03;
    localparam logic [7:0] ADDR_PRE     = 8'h04;
    localparam logic [7:0] ADDR_HALT    = 8'h05;
    localparam logic [7:0] ADDR_SPEC    = 8'h40;  // 0x40 + index
    localparam logic [7:0] ADDR_FILE    = 8'h80;  // 0x80 + address

    // status register bit positions
    localparam int ST_C  = 0;
    localparam int ST_HC = 1;
    localparam int ST_Z  = 2;
    localparam int ST_PD = 3;
    localparam int ST_TO = 4;

    localparam logic [7:0] ZERO8    = 8'h00;
    localparam logic [7:0] ACC_RST  = 8'h00;
    localparam logic [7:0] TMR_RST  = 8'h00;
    localparam logic       TO_RST   = 1'b1;
    localparam logic       PD_RST   = 1'b1;

    typedef enum logic [2:0] {
        SRX_OP_NOP,
        SRX_OP_SPEC_TO_ACC,
        SRX_OP_ACC_TO_SPEC,
        SRX_OP_REG_SUB,
        SRX_OP_IMM_SUB,
        SRX_OP_SWAP,
        SRX_OP_TMR_LOAD,
        SRX_OP_HALT
    } srx_op_t;
endpackage

// *** design/srx_alu_if.sv ***
// interface between the executor and its subtract / swap unit
`timescale 1ns/1ps
`default_nettype none
interface srx_alu_if;
    import srx_pkg::*;
    logic [DATA_W-1:0] minuend;
    logic [DATA_W-1:0] subtrahend;
    logic [DATA_W-1:0] diff;
    logic              zero;
    logic              half_carry;
    logic              carry;
    logic [DATA_W-1:0] swap_in;
    logic [DATA_W-1:0] swap_out;
    modport core (output minuend, output subtrahend, output swap_in,
                  input diff, input zero, input half_carry, input carry, input swap_out);
    modport alu  (input minuend, input subtrahend, input swap_in,
                  output diff, output zero, output half_carry, output carry, output swap_out);
endinterface
`default_nettype wire

// *** design/srx_alu.sv ***
// combinational subtract and nibble-swap unit
`timescale 1ns/1ps
`default_nettype none
module srx_alu
    import srx_pkg::*;
(
    srx_alu_if.alu a
);
    logic [DATA_W:0] full;
    logic [NIB:0]    low;

    // subtraction as m + ~s + 1 so carry means no borrow
    always_comb begin
        full         = {1'b0, a.minuend} + {1'b0, ~a.subtrahend} + 9'h001;
        low          = {1'b0, a.minuend[NIB-1:0]} + {1'b0, ~a.subtrahend[NIB-1:0]} + 5'h01;
        a.diff       = full[DATA_W-1:0];
        a.carry      = full[DATA_W];
        a.half_carry = low[NIB];
        a.zero       = (full[DATA_W-1:0] == ZERO8);
        a.swap_out   = {a.swap_in[NIB-1:0], a.swap_in[DATA_W-1:NIB]};
    end
endmodule
`default_nettype wire

// *** design/srx_exec.sv ***
// executor for special-page moves, subtracts, nibble swap, timer mode load and halt
`timescale 1ns/1ps
`default_nettype none
module srx_exec
    import srx_pkg::*;
#(
    parameter int SPEC_COUNT = SPEC_N,
    parameter int FILE_COUNT = FILE_N
) (
    input  wire logic                   sys_clk,
    input  wire logic                   sys_rst,
    // instruction issue, one per cycle
    input  wire logic                   op_valid,
    input  wire srx_op_t                op_code,
    input  wire logic [SPEC_IDX_W-1:0]  op_spec_idx,
    input  wire logic [FILE_ADDR_W-1:0] op_file_addr,
    input  wire logic                   op_dest,
    input  wire logic [DATA_W-1:0]      op_imm,
    // watchdog tick and wake from halt
    input  wire logic                   wdt_tick,
    input  wire logic                   wake,
    // register port
    input  wire logic [7:0]             reg_addr,
    input  wire logic [DATA_W-1:0]      reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic [DATA_W-1:0]           reg_rdata,
    // status outputs
    output logic [DATA_W-1:0]           accumulator,
    output logic [DATA_W-1:0]           timer_mode_register,
    output logic                        zero_flag,
    output logic                        half_carry_flag,
    output logic                        carry_flag,
    output logic                        timeout_flag,
    output logic                        powerdown_flag,
    output logic                        halted
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [DATA_W-1:0] acc;
        logic [DATA_W-1:0] tmode;
        logic              z;
        logic              hc;
        logic              c;
        logic              to;
        logic              pd;
        logic              halt;
        logic [WDT_W-1:0]  wdt;
        logic [PRE_W-1:0]  pre;
        logic [DATA_W-1:0] rdata;
    } srx_state_t;

    srx_state_t s_q;
    srx_state_t s_d;

    // register arrays kept apart from the struct: too large to copy each cycle
    logic [DATA_W-1:0] spec_q [SPEC_COUNT];
    logic [DATA_W-1:0] file_q [FILE_COUNT];

    srx_alu_if alu_bus ();

    srx_alu u_alu (
        .a (alu_bus)
    );

    // ==========================================================
    // helpers
    function automatic logic spec_ok(input logic [SPEC_IDX_W-1:0] i);
        spec_ok = (32'(i) < SPEC_COUNT);
    endfunction

    function automatic logic in_window(input logic [7:0] a, input logic [7:0] base,
                                       input int count);
        in_window = (a >= base) && (32'(a) < 32'(base) + count);
    endfunction

    logic exec;
    logic spec_wr_ins;
    logic file_wr_ins;
    logic [DATA_W-1:0] file_rd;
    logic [DATA_W-1:0] file_wval;
    logic [DATA_W-1:0] spec_rd;
    logic [FILE_ADDR_W-1:0] bus_faddr;
    logic [SPEC_IDX_W-1:0]  bus_sidx;
    logic bus_file_wr;
    logic bus_spec_wr;

    // instructions are ignored while halted
    assign exec      = op_valid && !s_q.halt;
    assign file_rd   = file_q[op_file_addr];
    assign spec_rd   = spec_ok(op_spec_idx) ? spec_q[op_spec_idx] : ZERO8;
    assign bus_faddr = reg_addr[FILE_ADDR_W-1:0];
    assign bus_sidx  = reg_addr[SPEC_IDX_W-1:0];
    assign bus_file_wr = reg_wr && reg_addr >= ADDR_FILE;
    assign bus_spec_wr = reg_wr && in_window(reg_addr, ADDR_SPEC, SPEC_COUNT);

    // operand steering to the subtract/swap unit
    always_comb begin
        alu_bus.minuend    = (op_code == SRX_OP_IMM_SUB) ? op_imm : file_rd;
        alu_bus.subtrahend = s_q.acc;
        alu_bus.swap_in    = file_rd;
    end

    // register-destination writes
    assign spec_wr_ins = exec && op_code == SRX_OP_ACC_TO_SPEC && spec_ok(op_spec_idx);
    assign file_wr_ins = exec && op_dest &&
                         (op_code == SRX_OP_REG_SUB || op_code == SRX_OP_SWAP);
    assign file_wval   = (op_code == SRX_OP_SWAP) ? alu_bus.swap_out : alu_bus.diff;

    // ==========================================================
    // next state
    always_comb begin
        s_d = s_q;
        // watchdog free-runs on its tick, prescaler wraps into counter
        if (wdt_tick) begin
            s_d.pre = s_q.pre + 1'b1;
            if (s_q.pre == {PRE_W{1'b1}}) begin
                s_d.wdt = s_q.wdt + 1'b1;
            end
        end
        if (s_q.halt && wake) begin
            s_d.halt = 1'b0;
        end
        if (exec) begin
            unique case (op_code)
                SRX_OP_NOP: begin
                end
                SRX_OP_SPEC_TO_ACC: begin
                    s_d.acc = spec_rd;
                end
                SRX_OP_ACC_TO_SPEC: begin
                end
                SRX_OP_REG_SUB: begin
                    if (!op_dest) begin
                        s_d.acc = alu_bus.diff;
                    end
                    s_d.z  = alu_bus.zero;
                    s_d.hc = alu_bus.half_carry;
                    s_d.c  = alu_bus.carry;
                end
                SRX_OP_IMM_SUB: begin
                    s_d.acc = alu_bus.diff;
                    s_d.z   = alu_bus.zero;
                    s_d.hc  = alu_bus.half_carry;
                    s_d.c   = alu_bus.carry;
                end
                SRX_OP_SWAP: begin
                    if (!op_dest) begin
                        s_d.acc = alu_bus.swap_out;
                    end
                end
                SRX_OP_TMR_LOAD: begin
                    s_d.tmode = s_q.acc;
                end
                SRX_OP_HALT: begin
                    s_d.wdt  = ZERO8;
                    s_d.pre  = ZERO8;
                    s_d.to   = 1'b1;
                    s_d.pd   = 1'b0;
                    s_d.halt = 1'b1;
                end
            endcase
        end
        // software writes of core registers
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_ACC:     s_d.acc   = reg_wdata;
                ADDR_TMRMODE: s_d.tmode = reg_wdata;
                ADDR_STATUS: begin
                    s_d.c  = reg_wdata[ST_C];
                    s_d.hc = reg_wdata[ST_HC];
                    s_d.z  = reg_wdata[ST_Z];
                end
                default: begin
                end
            endcase
        end
        // read data, one cycle after the strobe
        s_d.rdata = ZERO8;
        if (reg_rd) begin
            if (reg_addr == ADDR_ACC) begin
                s_d.rdata = s_q.acc;
            end else if (reg_addr == ADDR_STATUS) begin
                s_d.rdata = {3'b000, s_q.to, s_q.pd, s_q.z, s_q.hc, s_q.c};
            end else if (reg_addr == ADDR_TMRMODE) begin
                s_d.rdata = s_q.tmode;
            end else if (reg_addr == ADDR_WDT) begin
                s_d.rdata = s_q.wdt;
            end else if (reg_addr == ADDR_PRE) begin
                s_d.rdata = s_q.pre;
            end else if (reg_addr == ADDR_HALT) begin
                s_d.rdata = {7'h00, s_q.halt};
            end else if (in_window(reg_addr, ADDR_SPEC, SPEC_COUNT)) begin
                s_d.rdata = spec_q[bus_sidx];
            end else if (reg_addr >= ADDR_FILE) begin
                s_d.rdata = file_q[bus_faddr];
            end
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_q       <= '0;
            s_q.acc   <= ACC_RST;
            s_q.tmode <= TMR_RST;
            s_q.to    <= TO_RST;
            s_q.pd    <= PD_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // special and file arrays; instruction write wins over a bus write
    always_ff @(posedge sys_clk) begin
        if (spec_wr_ins) begin
            spec_q[op_spec_idx] <= s_q.acc;
        end else if (bus_spec_wr) begin
            spec_q[bus_sidx] <= reg_wdata;
        end
        if (file_wr_ins) begin
            file_q[op_file_addr] <= file_wval;
        end else if (bus_file_wr) begin
            file_q[bus_faddr] <= reg_wdata;
        end
    end

    // ==========================================================
    // outputs straight from flops
    assign reg_rdata           = s_q.rdata;
    assign accumulator         = s_q.acc;
    assign timer_mode_register = s_q.tmode;
    assign zero_flag           = s_q.z;
    assign half_carry_flag     = s_q.hc;
    assign carry_flag          = s_q.c;
    assign timeout_flag        = s_q.to;
    assign powerdown_flag      = s_q.pd;
    assign halted              = s_q.halt;
endmodule
`default_nettype wire

// *** testbench/srx_exec_monitor.sv ***
// checker for the executor's results at its top ports
`timescale 1ns/1ps
`default_nettype none
module srx_exec_monitor
    import srx_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              sys_rst,
    input wire logic              op_valid,
    input wire srx_op_t           op_code,
    input wire logic [DATA_W-1:0] op_imm,
    input wire logic              wake,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic [DATA_W-1:0] accumulator,
    input wire logic [DATA_W-1:0] timer_mode_register,
    input wire logic              zero_flag,
    input wire logic              half_carry_flag,
    input wire logic              carry_flag,
    input wire logic              timeout_flag,
    input wire logic              powerdown_flag,
    input wire logic              halted
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ==========================================
    // issue steps; a bus write beside an op would win, so it is left out
    sequence s_go(srx_op_t c);
        op_valid && !halted && !reg_wr && op_code == c;
    endsequence
    sequence s_quiet;
        op_valid && !halted && !reg_wr
            && op_code inside {SRX_OP_SPEC_TO_ACC, SRX_OP_ACC_TO_SPEC, SRX_OP_SWAP, SRX_OP_TMR_LOAD};
    endsequence
    sequence s_asleep;
        halted && !wake && !reg_wr;
    endsequence
    // ==========================================
    // results one cycle after the issuing edge
    imm_sub_value_a: assert property (s_go(SRX_OP_IMM_SUB) |=>
        accumulator == $past(op_imm) - $past(accumulator)) else $error("imm subtract value");
    imm_sub_carry_a: assert property (s_go(SRX_OP_IMM_SUB) |=>
        carry_flag == ($past(op_imm) >= $past(accumulator))) else $error("carry not no-borrow");
    imm_sub_zero_a: assert property (s_go(SRX_OP_IMM_SUB) |=>
        zero_flag == ($past(op_imm) == $past(accumulator))) else $error("zero flag wrong");
    flags_kept_a: assert property (s_quiet |=>
        $stable({zero_flag, half_carry_flag, carry_flag})) else $error("flags changed");
    tmr_load_a: assert property (s_go(SRX_OP_TMR_LOAD) |=>
        timer_mode_register == $past(accumulator)) else $error("timer mode load");
    halt_enter_a: assert property (s_go(SRX_OP_HALT) |=>
        timeout_flag && !powerdown_flag && halted) else $error("halt flags");
    halt_hold_a: assert property (s_asleep |=> halted && $stable(accumulator))
        else $error("op ran while halted");
    wake_exit_a: assert property (halted && wake && !reg_wr |=> !halted)
        else $error("wake ignored");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == ZERO8)
        else $error("read data not idle");
endmodule
bind srx_exec srx_exec_monitor i_mon (.sys_clk, .sys_rst, .op_valid, .op_code, .op_imm, .wake,
    .reg_wr, .reg_rd, .reg_rdata, .accumulator, .timer_mode_register, .zero_flag,
    .half_carry_flag, .carry_flag, .timeout_flag, .powerdown_flag, .halted);
`default_nettype wire

// *** testbench/special_reg_sub_swap_halt_exec_bench.sv ***
// self-checking bench for the executor with an integer reference model
`timescale 1ns/1ps
`default_nettype none
module special_reg_sub_swap_halt_exec_bench;
    import srx_pkg::*;
    logic       sys_clk, sys_rst, op_valid, op_dest, wdt_tick, wake, reg_wr, reg_rd, d;
    logic       zf, hf, cf, z_o, h_o, c_o, to_o, pd_o, hlt_o;
    logic [7:0] op_imm, reg_addr, reg_wdata, reg_rdata, acc_o, tmr_o, a, f, r, got;
    logic [6:0] op_file_addr, fa;
    logic [4:0] op_spec_idx, idx;
    srx_op_t    op_code;
    int         err_total, checks_done, seed, cyc, i;
    srx_exec i_dut (.sys_clk, .sys_rst, .op_valid, .op_code, .op_spec_idx, .op_file_addr,
        .op_dest, .op_imm, .wdt_tick, .wake, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .accumulator(acc_o), .timer_mode_register(tmr_o), .zero_flag(z_o),
        .half_carry_flag(h_o), .carry_flag(c_o), .timeout_flag(to_o),
        .powerdown_flag(pd_o), .halted(hlt_o));
    // ==========================================
    // compare, bus and issue tasks
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h, want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_wdata <= dt;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] ad);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 got = reg_rdata;
    endtask
    task automatic op(input srx_op_t c, input logic [4:0] s, input logic dd, input logic [7:0] im);
        @(posedge sys_clk);
        op_code <= c;
        op_spec_idx <= s;
        op_file_addr <= fa;
        op_dest <= dd;
        op_imm <= im;
        op_valid <= 1'b1;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        #1;
    endtask
    // subtract model: carry and half carry mean no borrow
    task automatic sub(input int m, input int s);
        r = 8'(m - s);
        cf = m >= s;
        hf = (m % 16) >= (s % 16);
        zf = r == 8'h00;
    endtask
    task give_verdict;
        $display("comparisons %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========================================
    // clock and hang guard; the run needs well under a thousand cycles
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            give_verdict();
        end
    end
    // ==========================================
    // main sequence
    initial begin
        {op_valid, op_dest, wdt_tick, wake, reg_wr, reg_rd} = 6'h00;
        {op_imm, reg_addr, reg_wdata, op_file_addr, op_spec_idx} = 36'h0_0000_0000;
        op_code = SRX_OP_NOP;
        {zf, hf, cf, fa} = 10'h000;
        seed = 6;
        sys_rst = 1'b1;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1 chk(acc_o, ACC_RST);
        chk(tmr_o, TMR_RST);
        chk({z_o, h_o, c_o, to_o, pd_o, hlt_o}, 6'h06);
        // software view of status, timer mode and halt registers
        wr(ADDR_STATUS, 8'h07);
        rd(ADDR_STATUS);
        chk(got, 8'h1f);
        wr(ADDR_STATUS, 8'h00);
        wr(ADDR_TMRMODE, 8'h3c);
        rd(ADDR_TMRMODE);
        chk(got, 8'h3c);
        rd(ADDR_HALT);
        chk(got, 8'h00);
        $display("test reset done");
        for (i = 0; i < 30; i++) begin
            a = 8'($random(seed));
            f = (i < 2) ? a : 8'($random(seed));   // equal operands: zero, no borrow
            fa = 7'($random(seed));
            d = 1'($random(seed));
            wr(ADDR_ACC, a);
            wr({1'b1, fa}, f);
            case (i % 5)
                0: begin
                    sub(f, a);
                    op(SRX_OP_REG_SUB, 5'h00, d, 8'h00);
                    if (d) f = r; else a = r;
                end
                1: begin
                    sub(f, a);
                    op(SRX_OP_IMM_SUB, 5'h00, 1'b0, f);
                    a = r;
                end
                2: begin
                    r = {f[3:0], f[7:4]};
                    op(SRX_OP_SWAP, 5'h00, d, 8'h00);
                    if (d) f = r; else a = r;
                end
                3: begin
                    idx = 5'(17 + i / 5);   // reaches 21 and the refused 22
                    op(SRX_OP_ACC_TO_SPEC, idx, 1'b0, 8'h00);
                    rd(8'(ADDR_SPEC + idx));
                    chk(got, (idx > 5'd21) ? 8'h00 : a);
                    wr(ADDR_ACC, ~a);
                    op(SRX_OP_SPEC_TO_ACC, idx, 1'b0, 8'h00);
                    if (idx > 5'd21) a = 8'h00;
                end
                default: begin
                    op(SRX_OP_TMR_LOAD, 5'h00, 1'b0, 8'h00);
                    chk(tmr_o, a);
                end
            endcase
            chk(acc_o, a);
            chk({z_o, h_o, c_o}, {zf, hf, cf});
            rd({1'b1, fa});
            chk(got, f);
        end
        $display("test operations done");
        @(posedge sys_clk);
        wdt_tick <= 1'b1;
        repeat (300) @(posedge sys_clk);
        wdt_tick <= 1'b0;
        rd(ADDR_WDT);
        chk(got, 8'h01);
        rd(ADDR_PRE);
        chk(got, 8'h2c);
        op(SRX_OP_HALT, 5'h00, 1'b0, 8'h00);
        chk({to_o, pd_o, hlt_o}, 3'b101);
        rd(ADDR_WDT);
        chk(got, 8'h00);
        rd(ADDR_PRE);
        chk(got, 8'h00);
        op(SRX_OP_IMM_SUB, 5'h00, 1'b0, 8'h55);
        chk(acc_o, a);
        rd(ADDR_HALT);
        chk(got, 8'h01);
        rd(ADDR_STATUS);
        chk(got, {3'b000, 2'b10, zf, hf, cf});
        rd(ADDR_ACC);
        chk(got, a);
        @(posedge sys_clk);
        wake <= 1'b1;
        @(posedge sys_clk);
        wake <= 1'b0;
        @(posedge sys_clk);
        #1 chk(hlt_o, 1'b0);
        $display("test halt done");
        give_verdict();
    end
endmodule
`default_nettype wire
